// ### include/xie_pkg.sv
// Package with opcode patterns, field positions and bus types for the XOR unit
package xie_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned BANK_W = 4;
  localparam int unsigned MSB_BIT = 7;

  // Opcode patterns on the upper instruction bits
  localparam logic [7:0] LIT_OPC = 8'h0A;
  localparam logic [5:0] REG_OPC = 6'h06;
  localparam int unsigned DEST_BIT = 9;
  localparam int unsigned BANK_BIT = 8;

  // Instruction field boundaries
  localparam int unsigned OPC_MSB = 15;
  localparam int unsigned LIT_OPC_LSB = 8;
  localparam int unsigned REG_OPC_LSB = 10;
  localparam int unsigned FIELD_MSB = 7;

  // Access bank: low half maps to bank 0, high half to the top bank
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  localparam logic [3:0] ACC_HI_BANK = 4'hF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef enum logic [1:0] {
    XIE_OP_NONE = 2'b00,
    XIE_OP_LIT = 2'b01,
    XIE_OP_REG = 2'b10
  } xie_op_t;

  // Data memory write request
  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] data;
  } xie_mem_wr_t;

  // Negative and zero flags with their update strobe
  typedef struct packed {
    logic upd;
    logic neg;
    logic zero;
  } xie_flags_t;

  // Whole registered state of the unit
  typedef struct packed {
    logic [7:0] working_register;
    xie_mem_wr_t mem_wr;
    xie_flags_t flags;
    logic hit;
  } xie_state_t;

endpackage

// ### core/xie_xor_exec.sv
// Decode and single-cycle execution of the two exclusive-OR instructions
`timescale 1ns/10ps
`default_nettype none

module xie_xor_exec (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [3:0] bank_select_register_i,
  input wire logic [7:0] mem_rdata_i,
  output logic [11:0] mem_raddr_o,
  output xie_pkg::xie_mem_wr_t mem_wr_o,
  output logic [7:0] working_register_o,
  output xie_pkg::xie_flags_t flags_o,
  output logic hit_o
);

  xie_pkg::xie_state_t state_r;
  xie_pkg::xie_state_t state_nxt;
  xie_pkg::xie_op_t op;
  logic dest_sel;
  logic bank_sel;
  logic lit_match;
  logic reg_match;
  logic [7:0] lit_field;
  logic [5:0] reg_field;
  logic [7:0] low_field;
  logic [7:0] operand;
  wire logic [7:0] result;
  logic [3:0] bank;

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  assign lit_field = instr_i[xie_pkg::OPC_MSB:xie_pkg::LIT_OPC_LSB];
  assign reg_field = instr_i[xie_pkg::OPC_MSB:xie_pkg::REG_OPC_LSB];
  assign low_field = instr_i[xie_pkg::FIELD_MSB:0];
  assign dest_sel = instr_i[xie_pkg::DEST_BIT];
  assign bank_sel = instr_i[xie_pkg::BANK_BIT];

  // The two patterns never overlap, so the order below is only a habit
  assign lit_match = (lit_field == xie_pkg::LIT_OPC);
  assign reg_match = (reg_field == xie_pkg::REG_OPC);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb
  begin
    op = xie_pkg::XIE_OP_NONE;
    if (instr_valid_i && lit_match)
    begin
      op = xie_pkg::XIE_OP_LIT;
    end
    else if (instr_valid_i && reg_match)
    begin
      op = xie_pkg::XIE_OP_REG;
    end
  end

  // ----------------------------------------------------------------
  // Data address
  // ----------------------------------------------------------------
  // Access bank splits the 8-bit field at its top bit
  always_comb
  begin
    if (bank_sel)
    begin
      bank = bank_select_register_i;
    end
    else if (low_field[xie_pkg::MSB_BIT])
    begin
      bank = xie_pkg::ACC_HI_BANK;
    end
    else
    begin
      bank = xie_pkg::ACC_LO_BANK;
    end
  end

  // Read address is combinational so the operand arrives the same cycle
  assign mem_raddr_o = {bank, low_field};

  // ----------------------------------------------------------------
  // Operand select and exclusive-OR datapath
  // ----------------------------------------------------------------
  assign operand = (op == xie_pkg::XIE_OP_LIT) ? low_field : mem_rdata_i;

  for (genvar i = 0; i < xie_pkg::DATA_W; i++)
  begin : g_xor
    assign result[i] = state_r.working_register[i] ^ operand[i];
  end

  // ----------------------------------------------------------------
  // Execute
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.mem_wr.we = 1'b0;
    state_nxt.flags.upd = 1'b0;
    state_nxt.hit = 1'b0;
    unique case (op)
      xie_pkg::XIE_OP_LIT:
      begin
        state_nxt.working_register = result;
      end
      xie_pkg::XIE_OP_REG:
      begin
        if (dest_sel)
        begin
          state_nxt.mem_wr.we = 1'b1;
          state_nxt.mem_wr.addr = mem_raddr_o;
          state_nxt.mem_wr.data = result;
        end
        else
        begin
          state_nxt.working_register = result;
        end
      end
      xie_pkg::XIE_OP_NONE:
      begin
      end
    endcase
    if (op != xie_pkg::XIE_OP_NONE)
    begin
      // Only N and Z move; other status is owned by the core
      state_nxt.flags.upd = 1'b1;
      state_nxt.flags.neg = result[xie_pkg::MSB_BIT];
      state_nxt.flags.zero = (result == xie_pkg::ZERO_BYTE);
      state_nxt.hit = 1'b1;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign mem_wr_o = state_r.mem_wr;
  assign working_register_o = state_r.working_register;
  assign flags_o = state_r.flags;
  assign hit_o = state_r.hit;

endmodule

`default_nettype wire

// ### verif/xie_monitor.sv
// Port assertions for the XOR execution unit
`timescale 1ns/10ps
`default_nettype none
module xie_monitor (
  input wire logic clock_i, rstn_i, instr_valid_i, hit_o,
  input wire logic [15:0] instr_i,
  input wire logic [3:0] bank_select_register_i,
  input wire logic [7:0] mem_rdata_i, working_register_o,
  input wire logic [11:0] mem_raddr_o,
  input wire xie_pkg::xie_mem_wr_t mem_wr_o,
  input wire xie_pkg::xie_flags_t flags_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  wire lt = instr_valid_i && instr_i[15:8] == 8'h0A;
  wire rg = instr_valid_i && instr_i[15:10] == 6'h06;
  wire [7:0] w = working_register_o;
  wire [7:0] r = w ^ (lt ? instr_i[7:0] : mem_rdata_i);
  sequence s_flg;
    flags_o.upd && flags_o.neg == $past(r[7]) && flags_o.zero == $past(!r);
  endsequence
  lit_res_a: assert property (lt |=> w == $past(r)) else $error("lit");
  lit_hit_a: assert property (
    lt |=> hit_o && !mem_wr_o.we) else $error("lit dec");
  reg_hit_a: assert property (rg |=> hit_o) else $error("reg dec");
  to_w_a: assert property (
    rg && !instr_i[9] |=> w == $past(r) && !mem_wr_o.we) else $error("w");
  to_f_a: assert property (
    rg && instr_i[9] |=> mem_wr_o.we && mem_wr_o.data == $past(r)
    && mem_wr_o.addr == $past(mem_raddr_o)) else $error("f");
  acc_bank_a: assert property (
    rg && !instr_i[8] |-> mem_raddr_o[11:8] == {4{instr_i[7]}}
    && mem_raddr_o[7:0] == instr_i[7:0]) else $error("access");
  bsr_bank_a: assert property (
    rg && instr_i[8] |-> mem_raddr_o == {bank_select_register_i,
    instr_i[7:0]}) else $error("bank");
  flag_upd_a: assert property (lt || rg |=> s_flg) else $error("flg");
  idle_quiet_a: assert property (
    !(lt || rg) |=> !hit_o && !flags_o.upd && !mem_wr_o.we)
    else $error("idle");
endmodule
bind xie_xor_exec xie_monitor mon (.*);
`default_nettype wire

// ### verif/testbench.sv
// Directed bench for the XOR execution unit
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clock_i = 1'h0, rstn_i = 1'h0, instr_valid_i = 1'h0, hit_o;
  logic [15:0] instr_i = 16'h0000;
  logic [3:0] bank_select_register_i = 4'h3;
  logic [7:0] mem_rdata_i = 8'h00, working_register_o, wm = 8'h00;
  logic [11:0] mem_raddr_o;
  xie_pkg::xie_mem_wr_t mem_wr_o;
  xie_pkg::xie_flags_t flags_o;
  int error_cnt = 0, n_compared = 0;
  xie_xor_exec uut (.*);
  initial forever #25 clock_i = ~clock_i;
  task automatic chk(input logic [20:0] s, e, input string m);
    n_compared++;
    error_cnt += (s !== e);
    if (s !== e) $display("CHECK FAILED %0t %s %h %h", $time, m, s, e);
  endtask
  task automatic op(input logic [15:0] i, input logic [7:0] d,
    input logic [11:0] a);
    logic lt;
    logic [7:0] r;
    lt = i[15:8] == 8'h0A;
    r = wm ^ (lt ? i[7:0] : d);
    @(posedge clock_i);
    instr_valid_i <= 1'h1;
    instr_i <= i;
    mem_rdata_i <= d;
    @(negedge clock_i);
    if (!lt) chk(mem_raddr_o, a, "addr");
    @(posedge clock_i);
    instr_valid_i <= 1'h0;
    mem_rdata_i <= ~d;
    @(negedge clock_i);
    if (lt || !i[9]) wm = r;
    chk(working_register_o, wm, "working_register");
    if (!lt && i[9]) chk(mem_wr_o, {1'h1, a, r}, "wr");
    else chk(mem_wr_o.we, 1'h0, "we");
    chk({hit_o, flags_o}, {2'h3, r[7], r == 8'h00}, "flg");
  endtask
  task automatic t_refused;
    @(posedge clock_i);
    instr_valid_i <= 1'h1;
    instr_i <= 16'h1C44;
    @(posedge clock_i);
    instr_i <= 16'h0A55;
    instr_valid_i <= 1'h0;
    @(negedge clock_i);
    chk({hit_o, flags_o.upd, mem_wr_o.we}, 3'h0, "opcode");
    @(posedge clock_i);
    @(negedge clock_i);
    chk({hit_o, working_register_o}, {1'h0, wm}, "valid");
  endtask
  task automatic t_reset;
    @(posedge clock_i);
    rstn_i <= 1'h0;
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'h1;
    @(negedge clock_i);
    wm = 8'h00;
    chk({working_register_o, flags_o, hit_o}, 12'h000, "rst");
    chk(mem_wr_o, 21'h000000, "rst wr");
  endtask
  task automatic t_lit;
    op(16'h0AB5, 8'h00, 12'h000);
    op(16'h0AAF, 8'h00, 12'h000);
  endtask
  // Second op reads back the running result, so it hits zero
  task automatic t_reg;
    op(16'h1890, 8'h0F, 12'hF90);
    op(16'h1B44, 8'h15, 12'h344);
    op(16'h1922, 8'hF0, 12'h322);
  endtask
  task automatic give_verdict;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clock_i);
    rstn_i <= 1'h1;
    t_lit;
    t_reg;
    t_refused;
    t_reset;
    t_lit;
    give_verdict;
  end
endmodule
`default_nettype wire
